/* pss_pkg.sv */
// Purpose: constants and types for the plasma sensor safety supervisor
// Assumes: 10 MHz pclk, APB register access, sensor samples on pclk
`default_nettype none

package pss_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WDOG_TIME_MS = 500;
  localparam int unsigned WDOG_CYCLES = (CLK_HZ / 1000) * WDOG_TIME_MS;
  localparam int unsigned WD_W = 23;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_KICK = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_HK = 8'h14;
  localparam logic [7:0] ADDR_LIM_BASE = 8'h20;
  localparam logic [7:0] ADDR_RATE_E = 8'h40;
  localparam logic [7:0] ADDR_RATE_I = 8'h44;
  localparam logic [7:0] ADDR_AMB = 8'h48;

  localparam int unsigned NUM_LV = 4;
  localparam int unsigned NUM_HV = 3;
  localparam int unsigned NUM_LIM = 7;

  // ctrl fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_HV_BIT = 2;

  // event bits
  localparam int unsigned EV_WDOG = 0;
  localparam int unsigned EV_LV = 1;
  localparam int unsigned EV_HV = 2;
  localparam int unsigned EV_RATE = 3;
  localparam int unsigned EV_AMB = 4;
  localparam int unsigned EV_W = 5;

  // reset values
  localparam logic [31:0] LIM_RST = 32'hffff_0000;
  localparam logic [31:0] RATE_RST = 32'h0001_ffff;
  localparam logic [31:0] AMB_RST = 32'hffff_ffff;
  localparam logic [4:0] MASK_RST = 5'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_LV, MODE_HV, MODE_PAUSE} pss_mode_t;

  typedef struct packed {
    logic valid;
    logic [NUM_LV-1:0][15:0] lv;
    logic [NUM_HV-1:0][15:0] hv;
    logic [1:0][15:0] rate;
  } pss_sens_t;

  typedef struct packed {
    logic valid;
    logic [15:0] pressure;
    logic [15:0] dust;
  } pss_amb_t;
endpackage : pss_pkg

`default_nettype wire

/* pss_supervisor.sv */
// Purpose: watchdog and sensor safety monitors with APB registers
// Assumes: sensor and ambient strobes come from logic on pclk
// Notes: pready answers one cycle into the access phase
//
// Decided for this implementation: the register offsets and the APB slave port.
`default_nettype none

module pss_supervisor #(
  parameter int unsigned WDOG_CYCLES = pss_pkg::WDOG_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensor samples
  input wire pss_pkg::pss_sens_t sens,
  input wire pss_pkg::pss_amb_t amb,
  // safety outputs
  output logic hv_enable,
  output var pss_pkg::pss_mode_t mode,
  output logic event_valid,
  output logic [pss_pkg::EV_W-1:0] event_code,
  output logic [6:0] hk_anomaly,
  output logic irq
);
  import pss_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic out_rng(input logic [15:0] v, input logic [31:0] l);
    out_rng = (v < l[15:0]) || (v > l[31:16]);
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= ADDR_HK) || (a >= ADDR_LIM_BASE && a <= ADDR_AMB);
  endfunction

  function automatic pss_mode_t dec_mode(input logic [1:0] c, input pss_mode_t cur);
    if (c == 2'h0) begin
      dec_mode = MODE_LV;
    end else if (c == 2'h1) begin
      dec_mode = MODE_HV;
    end else if (c == 2'h2) begin
      dec_mode = MODE_PAUSE;
    end else begin
      dec_mode = cur;
    end
  endfunction

  logic [31:0] lim [NUM_LIM];
  logic [31:0] rate_lim [2];
  logic [31:0] amb_lim;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic [WD_W-1:0] wd_cnt;
  logic [15:0] pers_cnt [2];
  logic acc, wr, rd, kick, ctrl_wr, wd_expire;
  logic [NUM_LV-1:0] lv_bad;
  logic [NUM_HV-1:0] hv_bad;
  logic [1:0] rate_over, rate_hit;
  logic lv_new, amb_trip, trip;
  logic [EV_W-1:0] ev;
  logic [31:0] next_rdata;
  pss_mode_t next_mode;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign kick = wr && paddr == ADDR_KICK;
  assign ctrl_wr = wr && paddr == ADDR_CTRL;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (paddr == ADDR_CTRL) begin
      next_rdata = {29'h0000_0000, hv_enable, mode};
    end else if (paddr == ADDR_STATUS) begin
      next_rdata = {9'h000, wd_cnt};
    end else if (paddr == ADDR_IRQ_STAT) begin
      next_rdata = {27'h0000_000, irq_stat};
    end else if (paddr == ADDR_IRQ_MASK) begin
      next_rdata = {27'h0000_000, irq_mask};
    end else if (paddr == ADDR_HK) begin
      next_rdata = {25'h0000_000, hk_anomaly};
    end else if (paddr >= ADDR_LIM_BASE && paddr < ADDR_RATE_E) begin
      if (paddr[4:2] < 3'(NUM_LIM)) begin
        next_rdata = lim[paddr[4:2]];
      end
    end else if (paddr == ADDR_RATE_E) begin
      next_rdata = rate_lim[0];
    end else if (paddr == ADDR_RATE_I) begin
      next_rdata = rate_lim[1];
    end else if (paddr == ADDR_AMB) begin
      next_rdata = amb_lim;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok(paddr);
      prdata <= (psel & penable & ~pready & ~pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // limit and interrupt mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_LIM; i++) begin
        lim[i] <= LIM_RST;
      end
      rate_lim[0] <= RATE_RST;
      rate_lim[1] <= RATE_RST;
      amb_lim <= AMB_RST;
      irq_mask <= MASK_RST;
    end else if (wr) begin
      for (int i = 0; i < NUM_LIM; i++) begin
        if (paddr == ADDR_LIM_BASE + 8'(4 * i)) begin
          lim[i] <= pwdata;
        end
      end
      if (paddr == ADDR_RATE_E) begin
        rate_lim[0] <= pwdata;
      end else if (paddr == ADDR_RATE_I) begin
        rate_lim[1] <= pwdata;
      end else if (paddr == ADDR_AMB) begin
        amb_lim <= pwdata;
      end else if (paddr == ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[EV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  assign wd_expire = mode != MODE_PAUSE && !kick && wd_cnt == WD_W'(WDOG_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt <= '0;
    end else if (kick || mode == MODE_PAUSE || wd_expire) begin
      wd_cnt <= '0;
    end else begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_LV; i++) begin
      lv_bad[i] = mode == MODE_LV && sens.valid && out_rng(sens.lv[i], lim[i]);
    end
    for (int j = 0; j < NUM_HV; j++) begin
      hv_bad[j] = hv_enable && sens.valid && out_rng(sens.hv[j], lim[NUM_LV+j]);
    end
    for (int k = 0; k < 2; k++) begin
      rate_over[k] = hv_enable && sens.valid && sens.rate[k] > rate_lim[k][15:0];
      rate_hit[k] = rate_over[k] && (17'(pers_cnt[k]) + 17'h1 >= 17'(rate_lim[k][31:16]));
    end
  end

  assign lv_new = |(lv_bad & ~hk_anomaly[NUM_LV-1:0]);
  assign amb_trip = hv_enable && amb.valid &&
    (amb.pressure > amb_lim[15:0] || amb.dust > amb_lim[31:16]);
  assign trip = |hv_bad || |rate_hit || amb_trip;
  assign ev = {amb_trip, |rate_hit, |hv_bad, lv_new, wd_expire};

  // persistence counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pers_cnt[0] <= 16'h0000;
      pers_cnt[1] <= 16'h0000;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (rate_over[k] && !rate_hit[k]) begin
          pers_cnt[k] <= pers_cnt[k] + 16'h0001;
        end else if (!hv_enable || sens.valid) begin
          pers_cnt[k] <= 16'h0000;
        end
      end
    end
  end

  // housekeeping flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hk_anomaly <= 7'h00;
    end else begin
      if (mode == MODE_LV && sens.valid) begin
        hk_anomaly[NUM_LV-1:0] <= lv_bad;
      end
      if (hv_enable && sens.valid) begin
        hk_anomaly[6:NUM_LV] <= hv_bad;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode and high voltage
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = dec_mode(pwdata[CTRL_MODE_LSB+:2], mode);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_LV;
    end else if (wd_expire) begin
      mode <= MODE_PAUSE;
    end else if (trip) begin
      mode <= MODE_LV;
    end else if (ctrl_wr) begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_enable <= 1'b0;
    end else if (wd_expire || trip) begin
      hv_enable <= 1'b0;
    end else if (ctrl_wr) begin
      hv_enable <= next_mode == MODE_HV && pwdata[CTRL_HV_BIT];
    end else if (mode != MODE_HV) begin
      hv_enable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_valid <= 1'b0;
      event_code <= '0;
    end else begin
      event_valid <= |ev;
      event_code <= ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= ((rd && paddr == ADDR_IRQ_STAT) ? '0 : irq_stat) | ev;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_shutdown;
    !hv_enable && mode == MODE_LV && event_valid;
  endsequence

  sequence s_hv_sample;
    hv_enable && sens.valid;
  endsequence

  AST_WDOG_EXPIRE: assert property (
    mode != MODE_PAUSE && !kick && wd_cnt == WD_W'(WDOG_CYCLES - 1) |=> event_code[EV_WDOG] && event_valid)
    else $error("watchdog did not flag expiry");
  AST_PAUSE_ENTRY: assert property (
    wd_expire |=> mode == MODE_PAUSE && !hv_enable ##1 (mode == MODE_PAUSE || $past(ctrl_wr)))
    else $error("pause mode not held after expiry");
  AST_KICK_RESTART: assert property (
    kick |=> wd_cnt == '0 ##1 (wd_cnt <= WD_W'(1)))
    else $error("refresh did not restart timer");
  AST_LV_CHECK: assert property (
    mode == MODE_LV && sens.valid && out_rng(sens.lv[1], lim[1]) |=> hk_anomaly[1])
    else $error("supply anomaly not in housekeeping");
  AST_LV_EVENT: assert property (
    lv_new |=> event_valid && event_code[EV_LV])
    else $error("supply anomaly event missing");
  AST_HV_RANGE: assert property (
    s_hv_sample ##0 out_rng(sens.hv[2], lim[NUM_LV+2]) |=> event_code[EV_HV])
    else $error("bulk monitor check missed");
  AST_HV_TRIP: assert property (
    s_hv_sample ##0 ((|hv_bad) && !wd_expire) |=> s_shutdown)
    else $error("hv monitor trip did not shut down");
  AST_RATE_TRIP: assert property (
    |rate_hit && !wd_expire |=> s_shutdown ##0 event_code[EV_RATE])
    else $error("count rate trip did not shut down");
  AST_AMB_TRIP: assert property (
    amb_trip && !wd_expire |=> s_shutdown ##0 event_code[EV_AMB])
    else $error("ambient trip did not shut down");
  AST_RATE_CLEAR: assert property (
    s_hv_sample ##0 !rate_over[0] |=> pers_cnt[0] == 16'h0000)
    else $error("persistence count not cleared");
  AST_IRQ_LEVEL: assert property (
    (irq_stat & irq_mask) != '0 |=> irq)
    else $error("interrupt not raised");
endmodule : pss_supervisor

`default_nettype wire

/* pss_sens_model.sv */
// Purpose: sensor and ambient message source facing the supervisor
// Assumes: strobes are one cycle wide on pclk
// Notes: sample data shows an inverted pattern between strobes
`default_nettype none

module pss_sens_model (
  // clock
  input wire logic pclk,
  // sample outputs
  output var pss_pkg::pss_sens_t sens,
  output var pss_pkg::pss_amb_t amb
);
  timeunit 1ns;
  timeprecision 1ns;
  import pss_pkg::*;

  initial begin
    sens = '0;
    amb = '0;
  end

  // ----------------------------------------------------------------
  // sample strobes
  // ----------------------------------------------------------------
  task automatic send_sens(input logic [63:0] lv, input logic [47:0] hv, input logic [31:0] rate);
    @(posedge pclk);
    sens <= {1'b1, lv, hv, rate};
    @(posedge pclk);
    sens <= {1'b0, ~lv, ~hv, ~rate};
  endtask

  task automatic send_amb(input logic [15:0] pres, input logic [15:0] dust);
    @(posedge pclk);
    amb <= {1'b1, pres, dust};
    @(posedge pclk);
    amb <= {1'b0, ~pres, ~dust};
  endtask
endmodule // pss_sens_model

`default_nettype wire

/* tb_plasma_sensor_safety_supervisor.sv */
// Purpose: self-checking bench for the safety supervisor
// Assumes: short watchdog period set by parameter
// Notes: apb tasks wait for pready under a bounded count
`default_nettype none

module tb_plasma_sensor_safety_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  import pss_pkg::*;

  localparam int unsigned WD = 400;
  localparam logic [63:0] LV_OK = 64'h0000_0000_0800_0000;
  localparam logic [63:0] LV_BAD = 64'h0000_0000_2000_0000;
  localparam logic [47:0] HV_OK = 48'h2000_0000_2000;
  localparam logic [47:0] HV_BAD = 48'h0500_0000_0500;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  pss_sens_t sens;
  pss_amb_t amb;
  logic hv_enable, event_valid, irq;
  pss_mode_t mode;
  logic [4:0] event_code;
  logic [6:0] hk_anomaly;
  int errors, samples_checked, n;
  logic [5:0] ov;

  pss_supervisor #(.WDOG_CYCLES(WD)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sens(sens), .amb(amb), .hv_enable(hv_enable), .mode(mode), .event_valid(event_valid),
    .event_code(event_code), .hk_anomaly(hk_anomaly), .irq(irq));

  pss_sens_model m (.pclk(pclk), .sens(sens), .amb(amb));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done(input logic timeout);
    if (timeout) errors++;
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) test_done(1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  task automatic evt(input logic [4:0] c);
    #1;
    check({event_valid, event_code}, {c != 5'h00, c});
  endtask

  task automatic hv_on();
    wr(ADDR_KICK, 32'h0);
    wr(ADDR_CTRL, 32'h5);
    #1;
    check({hv_enable, mode}, {1'b1, MODE_HV});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check({hv_enable, irq, mode}, {1'b0, 1'b0, MODE_LV});
    rdc(ADDR_IRQ_MASK, {27'h0, MASK_RST});
    rdc(ADDR_LIM_BASE + 8'h08, LIM_RST);
    rdc(ADDR_RATE_E, RATE_RST);
    rdc(ADDR_AMB, AMB_RST);
    apb(1'b0, 8'h18, 32'h0);
    check({q, e}, {32'h0, 1'b1});
    wr(ADDR_LIM_BASE + 8'h04, 32'h1000_0100);
    wr(ADDR_IRQ_MASK, 32'h02);
    // watchdog expiry and pause
    wr(ADDR_KICK, 32'h0);
    n = 0;
    while (mode !== MODE_PAUSE && n < 2 * WD) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check(n >= WD - 3 && n <= WD + 3, 1);
    check({hv_enable, irq}, 2'b00);
    m.send_sens(LV_BAD, HV_OK, 32'h0);
    evt(5'h00);
    rdc(ADDR_STATUS, 32'h0);
    rdc(ADDR_IRQ_STAT, 32'h01);
    wr(ADDR_CTRL, 32'h0);
    #1;
    check(mode, MODE_LV);
    // code 3 keeps the mode, hv bit ignored outside hv mode
    wr(ADDR_CTRL, 32'h7);
    #1;
    check({hv_enable, mode}, {1'b0, MODE_LV});
    // supply anomaly, interrupt and read clear
    wr(ADDR_KICK, 32'h0);
    rdc(ADDR_STATUS, 32'h2);
    m.send_sens(LV_BAD, HV_OK, 32'h0);
    evt(5'h02);
    @(posedge pclk);
    #1;
    check(irq, 1'b1);
    rdc(ADDR_HK, 32'h02);
    rdc(ADDR_IRQ_STAT, 32'h02);
    rdc(ADDR_IRQ_STAT, 32'h00);
    check(irq, 1'b0);
    m.send_sens(LV_OK, HV_OK, 32'h0);
    evt(5'h00);
    // high-voltage monitor trip
    wr(ADDR_LIM_BASE + 8'h10, 32'h8000_1000);
    wr(ADDR_LIM_BASE + 8'h18, 32'h8000_1000);
    hv_on();
    m.send_sens(LV_OK, HV_OK, 32'h0);
    evt(5'h00);
    m.send_sens(LV_OK, HV_BAD, 32'h0);
    evt(5'h04);
    check({hv_enable, mode}, {1'b0, MODE_LV});
    rdc(ADDR_HK, 32'h50);
    // count rate persistence
    wr(ADDR_RATE_E, 32'h0003_0100);
    wr(ADDR_RATE_I, 32'h0001_0100);
    hv_on();
    ov = 6'b111011;
    for (int i = 0; i < 6; i++) begin
      m.send_sens(LV_OK, HV_OK, {16'h0050, ov[i] ? 16'h0200 : 16'h0050});
      evt(i == 5 ? 5'h08 : 5'h00);
    end
    check(hv_enable, 1'b0);
    hv_on();
    m.send_sens(LV_OK, HV_OK, {16'h0200, 16'h0050});
    evt(5'h08);
    // ambient limits
    wr(ADDR_AMB, 32'h0200_0300);
    for (int k = 0; k < 2; k++) begin
      hv_on();
      m.send_amb(k ? 16'h0100 : 16'h0400, k ? 16'h0300 : 16'h0100);
      evt(5'h10);
      check({hv_enable, mode}, {1'b0, MODE_LV});
    end
    m.send_amb(16'h0400, 16'h0100);
    evt(5'h00);
    // commanded pause holds the watchdog at zero
    wr(ADDR_CTRL, 32'h2);
    #1;
    check(mode, MODE_PAUSE);
    rdc(ADDR_STATUS, 32'h0);
    test_done(1'b0);
  end
endmodule // tb_plasma_sensor_safety_supervisor

`default_nettype wire
